// ---- include/demod_setup_pkg.sv ----
// Constants for the demodulator setup register bank
package demod_setup_pkg;
   // Target codes in bits 4:0 of each serial word
   localparam logic [4:0] ADDR_RX_CHAIN = 5'h09;
   localparam logic [4:0] ADDR_OFFSET_CAL = 5'h0a;
   localparam logic [4:0] ADDR_READBACK_CMD = 5'h08;
   localparam int ADDR_LSB = 0;
   localparam int ADDR_MSB = 4;
   // Readback command word fields
   localparam int RB_ENABLE_BIT = 31;
   localparam int RB_SEL_LSB = 28;
   localparam logic [2:0] RB_SEL_RX_CHAIN = 3'h1;
   localparam logic [2:0] RB_SEL_OFFSET_CAL = 3'h2;
   // First setup register field positions
   localparam int MIXER_PD_BIT = 5;
   localparam int TEST_BUF_PD_BIT = 7;
   localparam int FILTER_PD_BIT = 8;
   localparam int OFFSET_CAL_PD_BIT = 10;
   localparam int GAIN_LSB = 12;
   localparam int CORNER_LSB = 17;
   localparam int DET_R_BIT = 25;
   localparam int DET_C_BIT = 26;
   localparam int FAST_GAIN_EN_BIT = 27;
   localparam int FAST_GAIN_X2_BIT = 28;
   localparam int OSC_TEST_BIT = 29;
   localparam int ATTEN_BIT = 31;
   // Bits written but ignored: 6, 9, 11, 30
   localparam logic [31:0] RX_CHAIN_IGNORED_MASK = 32'h4000_0a40;
   // Second setup register field positions
   localparam int AUTOCAL_BIT = 5;
   localparam int IDAC_LSB = 6;
   localparam int OFFSET_CAL_WIDTH = 14;
   // Reset values, address bits included; then the gain ceiling and the readback bit count
   localparam logic [31:0] RX_CHAIN_RESET = 32'h0100_fc89;
   localparam logic [13:0] OFFSET_CAL_RESET = 14'h200a;
   localparam logic [4:0] GAIN_MAX = 5'h18;
   localparam logic [5:0] RB_BITS = 6'h20;
endpackage : demod_setup_pkg

// ---- rtl/demod_setup_regs.sv ----
// Serial-loaded setup registers one and two with readback
`timescale 1ns/1ps

// Overview of operation
// (R01) Bit 5 set powers down the mixer; default 0.
// (R02) Bit 7 set powers down the mixer test buffer; default 1.
// (R03) Bit 8 set powers down the baseband filter; default 0.
// (R04) Bit 10 set powers down offset calibration logic; default 1.
// (R05) Gain code bits 16:12, valid 0 to 24, default 15.
// (R06) Corner code bits 24:17, 255 lowest, 0 highest, default 128.
// (R07) Bits 26:25 select detector bandwidth 10 MHz, 10 kHz, 1 kHz.
// (R08) Low bit enables detector resistor, high bit its capacitor.
// (R09) Low bit zero bypasses both elements regardless of high bit.
// (R10) Bit 27 enables external fast gain control; default 0.
// (R11) Bit 28 doubles the fast gain step; default 0.
// (R12) Bit 29 routes the calibration oscillator onto the readback pin.
// (R13) Bit 31 switches in the 3 dB output attenuator; default 0.
// (R14) Writing bit 5 of register two starts autocal; cleared when done.
// (R15) Controller writes the in-phase offset code in bits 13:6; MSB default 1.
// (R16) Bits 4:0 select target: 0x09 register one, 0x0a register two.
// (R17) Unused bits 6, 9, 11, 30 are ignored by the device.
// (R18) Words shift in LSB first on serial clock rising edges.
// (R19) Load strobe rising edge copies the shift register to the target.
// (R20) Readback: one idle clock, then 32 bits LSB first on rising edges.
module demod_setup_regs
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Three-wire serial link
   input wire logic serial_clk_i,
   input wire logic serial_data_i,
   input wire logic load_strobe_i,
   output logic readback_o,
   // Calibration engine
   input wire logic cal_done_i,
   input wire logic cal_osc_i,
   output logic autocal_start_o,
   output logic [7:0] inphase_offset_dac_code_o,
   // Receive chain controls
   output logic mixer_power_down_o,
   output logic test_buffer_power_down_o,
   output logic filter_power_down_o,
   output logic offset_cal_power_down_o,
   output logic [4:0] baseband_gain_code_o,
   output logic [7:0] corner_freq_code_o,
   output logic detector_resistor_enable_o,
   output logic detector_capacitor_enable_o,
   output logic ext_fast_gain_enable_o,
   output logic fast_gain_double_o,
   output logic output_attenuator_enable_o
);

   typedef struct packed {
      logic [2:0] sclk_sync;
      logic [1:0] sdata_sync;
      logic [2:0] strobe_sync;
      logic [1:0] osc_sync;
      logic [31:0] shift;
      logic [31:0] rx_chain;
      logic [13:0] offset_cal;
      logic rb_armed;
      logic rb_active;
      logic [5:0] rb_count;
      logic [31:0] rb_word;
      logic rb_bit;
      logic pin;
      logic [4:0] gain;
      logic det_cap;
   } state_s;

   state_s q;
   state_s d;

   logic sclk_rise;
   logic strobe_rise;
   logic [4:0] target;
   logic [31:0] rx_chain_view;
   logic [31:0] offset_cal_view;

   // Link pins and cal_osc_i are sampled twice before use (cal_done_i is not); edges come from stages two and three
   assign sclk_rise = q.sclk_sync[1] & ~q.sclk_sync[2]; // R18
   assign strobe_rise = q.strobe_sync[1] & ~q.strobe_sync[2]; // R19
   assign target = q.shift[demod_setup_pkg::ADDR_MSB:demod_setup_pkg::ADDR_LSB];
   assign rx_chain_view = q.rx_chain;
   assign offset_cal_view = {18'h00000, q.offset_cal};

   always_comb
   begin
      d = q;
      d.sclk_sync = {q.sclk_sync[1:0], serial_clk_i};
      d.sdata_sync = {q.sdata_sync[0], serial_data_i};
      d.strobe_sync = {q.strobe_sync[1:0], load_strobe_i};
      d.osc_sync = {q.osc_sync[0], cal_osc_i};

      // Calibration done clears the start bit; a write below wins
      if (cal_done_i)
      begin
         d.offset_cal[demod_setup_pkg::AUTOCAL_BIT] = 1'b0; // R14
      end

      if (sclk_rise)
      begin
         d.shift = {q.sdata_sync[1], q.shift[31:1]}; // R18
         if (q.rb_armed)
         begin
            // First clock after the strobe is idle
            d.rb_armed = 1'b0; // R20
            d.rb_active = 1'b1;
            d.rb_count = 6'h00;
         end
         else if (q.rb_active)
         begin
            d.rb_bit = q.rb_word[q.rb_count[4:0]]; // R20
            d.rb_count = q.rb_count + 6'h01;
            if (q.rb_count == demod_setup_pkg::RB_BITS - 6'h01)
            begin
               d.rb_active = 1'b0;
            end
         end
      end

      if (strobe_rise)
      begin
         case (target) // R16
            demod_setup_pkg::ADDR_RX_CHAIN:
            begin
               // Ignored bits keep their defaults
               d.rx_chain = (q.shift & ~demod_setup_pkg::RX_CHAIN_IGNORED_MASK)
                  | (demod_setup_pkg::RX_CHAIN_RESET
                  & demod_setup_pkg::RX_CHAIN_IGNORED_MASK); // R17 R19
               d.rx_chain[demod_setup_pkg::ADDR_MSB:0] =
                  demod_setup_pkg::ADDR_RX_CHAIN;
            end
            demod_setup_pkg::ADDR_OFFSET_CAL:
            begin
               d.offset_cal =
                  q.shift[demod_setup_pkg::OFFSET_CAL_WIDTH-1:0]; // R14 R19
               d.offset_cal[demod_setup_pkg::ADDR_MSB:0] =
                  demod_setup_pkg::ADDR_OFFSET_CAL;
            end
            demod_setup_pkg::ADDR_READBACK_CMD:
            begin
               if (q.shift[demod_setup_pkg::RB_ENABLE_BIT])
               begin
                  d.rb_armed = 1'b1; // R20
                  d.rb_active = 1'b0;
                  case (q.shift[demod_setup_pkg::RB_SEL_LSB +: 3])
                     demod_setup_pkg::RB_SEL_RX_CHAIN:
                        d.rb_word = rx_chain_view;
                     demod_setup_pkg::RB_SEL_OFFSET_CAL:
                        d.rb_word = offset_cal_view;
                     default:
                        d.rb_word = 32'h0000_0000;
                  endcase
               end
            end
            default:
            begin
               // Other targets belong to other banks
               d.rb_armed = q.rb_armed;
            end
         endcase
      end

      // Oscillator test overrides normal readback
      if (q.rx_chain[demod_setup_pkg::OSC_TEST_BIT])
      begin
         d.pin = q.osc_sync[1]; // R12
      end
      else
      begin
         d.pin = d.rb_bit;
      end

      if (reset_i)
      begin
         d = '0;
         d.rx_chain = demod_setup_pkg::RX_CHAIN_RESET; // R01 R02 R03 R04
         d.offset_cal = demod_setup_pkg::OFFSET_CAL_RESET; // R15
      end

      // Derived controls sit in flops so every output is a clean register
      if (d.rx_chain[demod_setup_pkg::GAIN_LSB +: 5]
         > demod_setup_pkg::GAIN_MAX)
      begin
         // Codes above the top step would overdrive the amplifier
         d.gain = demod_setup_pkg::GAIN_MAX; // R05
      end
      else
      begin
         d.gain = d.rx_chain[demod_setup_pkg::GAIN_LSB +: 5];
      end
      d.det_cap = d.rx_chain[demod_setup_pkg::DET_R_BIT]
         & d.rx_chain[demod_setup_pkg::DET_C_BIT]; // R08 R09
   end

   always_ff @(posedge clk_i)
   begin
      q <= d;
   end

   assign readback_o = q.pin;
   assign autocal_start_o = q.offset_cal[demod_setup_pkg::AUTOCAL_BIT]; // R14
   assign inphase_offset_dac_code_o =
      q.offset_cal[demod_setup_pkg::IDAC_LSB +: 8]; // R15
   assign mixer_power_down_o =
      q.rx_chain[demod_setup_pkg::MIXER_PD_BIT]; // R01
   assign test_buffer_power_down_o =
      q.rx_chain[demod_setup_pkg::TEST_BUF_PD_BIT]; // R02
   assign filter_power_down_o =
      q.rx_chain[demod_setup_pkg::FILTER_PD_BIT]; // R03
   assign offset_cal_power_down_o =
      q.rx_chain[demod_setup_pkg::OFFSET_CAL_PD_BIT]; // R04

   // Readback shows the stored code; only the output is held at max
   assign baseband_gain_code_o = q.gain; // R05

   assign corner_freq_code_o =
      q.rx_chain[demod_setup_pkg::CORNER_LSB +: 8]; // R06
   assign detector_resistor_enable_o =
      q.rx_chain[demod_setup_pkg::DET_R_BIT]; // R07 R08
   assign detector_capacitor_enable_o = q.det_cap; // R08 R09
   assign ext_fast_gain_enable_o =
      q.rx_chain[demod_setup_pkg::FAST_GAIN_EN_BIT]; // R10
   assign fast_gain_double_o =
      q.rx_chain[demod_setup_pkg::FAST_GAIN_X2_BIT]; // R11
   assign output_attenuator_enable_o =
      q.rx_chain[demod_setup_pkg::ATTEN_BIT]; // R13

endmodule : demod_setup_regs

// ---- verif/demod_setup_regs_assertions.sv ----
// Checker for the demodulator setup register bank
`timescale 1ns/1ps
module demod_setup_regs_assertions
(
   // Watched ports
   input wire logic clk_i, reset_i, load_strobe_i, cal_done_i,
   input wire logic autocal_start_o, mixer_power_down_o,
   input wire logic test_buffer_power_down_o, filter_power_down_o,
   input wire logic offset_cal_power_down_o, detector_resistor_enable_o,
   input wire logic detector_capacitor_enable_o,
   input wire logic [4:0] baseband_gain_code_o,
   input wire logic [7:0] corner_freq_code_o, inphase_offset_dac_code_o
);
   logic strb_q;
   logic [3:0] since_q;
   // Strobe is asynchronous, so outputs may move up to 6 cycles after it
   always_ff @(posedge clk_i)
   begin
      strb_q <= load_strobe_i;
      if (reset_i || (load_strobe_i && !strb_q))
         since_q <= 4'h0;
      else if (since_q != 4'hf)
         since_q <= since_q + 4'h1;
   end
   default clocking @(posedge clk_i); endclocking
   a_reset_power: assert property (
      reset_i |=> {mixer_power_down_o, test_buffer_power_down_o,
      filter_power_down_o, offset_cal_power_down_o} == 4'h5)
      else $error("power-down defaults wrong");
   a_reset_fields: assert property (reset_i |=>
      baseband_gain_code_o == 5'h0f && corner_freq_code_o == 8'h80)
      else $error("gain or corner default wrong");
   a_reset_cal: assert property (reset_i |=>
      !autocal_start_o && inphase_offset_dac_code_o == 8'h80)
      else $error("calibration defaults wrong");
   a_gain_range: assert property (disable iff (reset_i)
      baseband_gain_code_o <= demod_setup_pkg::GAIN_MAX)
      else $error("gain code above range");
   a_det_bypass: assert property (disable iff (reset_i)
      detector_capacitor_enable_o |-> detector_resistor_enable_o)
      else $error("capacitor enabled with resistor bypassed");
   a_regs_hold: assert property (disable iff (reset_i)
      since_q > 4'h6 |=> $stable({mixer_power_down_o, corner_freq_code_o,
      baseband_gain_code_o, inphase_offset_dac_code_o}))
      else $error("control changed without a strobe");
   a_autocal_clear: assert property (disable iff (reset_i)
      autocal_start_o && cal_done_i && since_q > 4'h6 |=> !autocal_start_o)
      else $error("autocal not cleared when done");
   a_autocal_rise: assert property (disable iff (reset_i)
      $rose(autocal_start_o) |-> since_q <= 4'h6)
      else $error("autocal set without a strobe");
endmodule : demod_setup_regs_assertions

bind demod_setup_regs demod_setup_regs_assertions i_demod_setup_regs_assertions
(
   .clk_i, .reset_i, .load_strobe_i, .cal_done_i, .autocal_start_o,
   .mixer_power_down_o, .test_buffer_power_down_o, .filter_power_down_o,
   .offset_cal_power_down_o, .detector_resistor_enable_o,
   .detector_capacitor_enable_o, .baseband_gain_code_o,
   .corner_freq_code_o, .inphase_offset_dac_code_o
);

// ---- verif/serial_ctrl_model.sv ----
// Controller model for the three-wire setup link
`timescale 1ns/1ps
module serial_ctrl_model
(
   // Link pins
   output logic sclk_o,
   output logic data_o,
   output logic strobe_o,
   input wire logic readback_i
);
   initial
   begin
      sclk_o = 1'b0;
      data_o = 1'b0;
      strobe_o = 1'b0;
   end
   task automatic write_word(input logic [31:0] w);
      for (int i = 0; i < 32; i++)
      begin
         data_o = w[i];
         #62.5 sclk_o = 1'b1;
         #62.5 sclk_o = 1'b0;
      end
      // Released data shows the inverse so a stale bit is never trusted
      data_o = ~data_o;
      #62.5 strobe_o = 1'b1;
      #62.5 strobe_o = 1'b0;
      #62.5;
   endtask : write_word
   task automatic read_word(input logic [2:0] sel, output logic [31:0] r);
      logic [31:0] cmd;
      cmd = 32'h0;
      cmd[demod_setup_pkg::RB_ENABLE_BIT] = 1'b1;
      cmd[30:28] = sel;
      cmd[4:0] = demod_setup_pkg::ADDR_READBACK_CMD;
      write_word(cmd);
      for (int i = -1; i < 32; i++)
      begin
         #62.5 sclk_o = 1'b1;
         #62.5 sclk_o = 1'b0;
         if (i >= 0)
            r[i] = readback_i;
      end
   endtask : read_word
endmodule : serial_ctrl_model

// ---- verif/demod_setup_regs_tb_top.sv ----
// Testbench for the demodulator setup register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
   mismatches++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module demod_setup_regs_tb_top;
   logic clk_i = 1'b0, reset_i = 1'b1, cal_done_i = 1'b0, cal_osc_i = 1'b0;
   logic serial_clk_i, serial_data_i, load_strobe_i, readback_o;
   logic autocal_start_o, mixer_power_down_o, test_buffer_power_down_o;
   logic filter_power_down_o, offset_cal_power_down_o, fast_gain_double_o;
   logic detector_resistor_enable_o, detector_capacitor_enable_o;
   logic ext_fast_gain_enable_o, output_attenuator_enable_o;
   logic [4:0] baseband_gain_code_o;
   logic [7:0] corner_freq_code_o, inphase_offset_dac_code_o;
   logic [31:0] w, rd;
   logic [31:0] pick [4] = '{32'h0, 32'hffff_ffff, 32'h0200_0000,
      32'h0400_0000};
   int mismatches = 0, total_checks = 0;
   wire logic [21:0] ctl = {mixer_power_down_o, test_buffer_power_down_o,
      filter_power_down_o, offset_cal_power_down_o, baseband_gain_code_o,
      corner_freq_code_o, detector_resistor_enable_o,
      detector_capacitor_enable_o, ext_fast_gain_enable_o,
      fast_gain_double_o, output_attenuator_enable_o};
   wire logic [8:0] cal_ctl = {inphase_offset_dac_code_o, autocal_start_o};
   always #5 clk_i = ~clk_i;
   demod_setup_regs i_demod_setup_regs (.clk_i, .reset_i, .serial_clk_i,
      .serial_data_i, .load_strobe_i, .readback_o, .cal_done_i, .cal_osc_i,
      .autocal_start_o, .inphase_offset_dac_code_o, .mixer_power_down_o,
      .test_buffer_power_down_o, .filter_power_down_o,
      .offset_cal_power_down_o, .baseband_gain_code_o, .corner_freq_code_o,
      .detector_resistor_enable_o, .detector_capacitor_enable_o,
      .ext_fast_gain_enable_o, .fast_gain_double_o,
      .output_attenuator_enable_o);
   serial_ctrl_model i_serial_ctrl_model (.sclk_o(serial_clk_i),
      .data_o(serial_data_i), .strobe_o(load_strobe_i),
      .readback_i(readback_o));
   // Unused bits keep their defaults whatever was shifted in
   function automatic logic [31:0] exp_r1(input logic [31:0] v);
      return (v & ~32'h4000_0a40) | 32'h0000_0800;
   endfunction : exp_r1
   function automatic logic [21:0] exp_ctl(input logic [31:0] r);
      return {r[5], r[7], r[8], r[10], (r[16:12] > 5'h18) ? 5'h18 : r[16:12],
         r[24:17], r[25], r[25] & r[26], r[27], r[28], r[31]};
   endfunction : exp_ctl
   task automatic chk_r1(input logic [31:0] r);
      logic [21:0] want;
      want = exp_ctl(r);
      `CHK("power", want[21:5], ctl[21:5])
      `CHK("detector", want[4:0], ctl[4:0])
      i_serial_ctrl_model.read_word(3'h1, rd);
      `CHK("register one", r, rd)
   endtask : chk_r1
   task automatic chk_r2(input logic [31:0] r);
      `CHK("dac and autocal", r[13:5], cal_ctl)
      i_serial_ctrl_model.read_word(3'h2, rd);
      `CHK("register two", r, rd)
   endtask : chk_r2
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   initial
   begin
      #900000;
      mismatches++;
      print_verdict();
   end
   initial
   begin
      w = $urandom(71619);
      repeat (8) @(posedge clk_i);
      @(negedge clk_i) reset_i = 1'b0;
      repeat (3) @(negedge clk_i);
      chk_r1(32'h0100_fc89);
      chk_r2(32'h0000_200a);
      for (int n = 0; n < 10; n++)
      begin
         w = (n < 4) ? pick[n] : $urandom;
         w[4:0] = demod_setup_pkg::ADDR_RX_CHAIN;
         w[29] = 1'b0;
         i_serial_ctrl_model.write_word(w);
         chk_r1(exp_r1(w));
      end
      // Unknown target must leave register one as it was
      i_serial_ctrl_model.write_word({~w[31:5], 5'h0b});
      chk_r1(exp_r1(w));
      // A select with no register behind it reads back as zero
      i_serial_ctrl_model.read_word(3'h3, rd);
      `CHK("unknown select", 32'h0, rd)
      for (int n = 0; n < 3; n++)
      begin
         w = $urandom;
         i_serial_ctrl_model.write_word({w[31:6], 6'h2a});
         chk_r2({18'h0, w[13:6], 6'h2a});
         @(negedge clk_i) cal_done_i = 1'b1;
         @(negedge clk_i) cal_done_i = 1'b0;
         chk_r2({18'h0, w[13:6], 6'h0a});
      end
      i_serial_ctrl_model.write_word(32'h2100_f489);
      for (int n = 0; n < 4; n++)
      begin
         @(negedge clk_i) cal_osc_i = n[0];
         repeat (6) @(negedge clk_i);
         `CHK("oscillator on readback", n[0], readback_o)
      end
      print_verdict();
   end
endmodule : demod_setup_regs_tb_top
